// ===== logic/flash_status_protect_consts.vh
// Notes on behaviour
// - Ready flag low during auto operation
// - Faulted operation keeps flag low until reset
// - Bit 2 reports flash or mask ROM
// - Bits 7:4 report per-block protection
// - Program to protected block is refused
// - Status register read-only, reserved bits zero
// - Protect enable bit 0, power-on sets one
// - Protection active needs enable and all blocks
// - Active protection blocks non-ROM access to the protect control register
`ifndef FLASH_STATUS_PROTECT_CONSTS_VH
`define FLASH_STATUS_PROTECT_CONSTS_VH
`define ROM_PROTECT_CONTROL_ADDR 32'hFFFFE518
`define FLASH_CONTROL_STATUS_ADDR 32'hFFFFE520
`define IRQ_STATUS_ADDR 32'hFFFFE524
`define IRQ_MASK_ADDR 32'hFFFFE528
`define FLASH_COMMAND_ADDR 32'hFFFFE52C
`define FCS_READY_BIT 0
`define FCS_KIND_BIT 2
`define FCS_PROT_LSB 4
`define FCS_PROT_MSB 7
`define ROM_PROT_RESET 1'b1
`define IRQ_DONE_BIT 0
`define IRQ_FAULT_BIT 1
`define IRQ_REFUSED_BIT 2
`define IRQ_WIDTH 3
`define CMD_START 2'h1
`define CMD_RESET 2'h2
`define ALL_BLOCKS 4'hF
`endif

// ===== logic/auto_op_sequencer.v
`timescale 1ns/10ps
`include "flash_status_protect_consts.vh"
// Tracks one automatic flash operation and its ready flag
module auto_op_sequencer
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Command side
  input wire start_pulse,
  input wire reset_cmd_pulse,
  input wire target_protected,
  // Flash array side
  input wire array_done,
  input wire array_fault,
  output reg array_go,
  // Status
  output reg ready_reg,
  output reg done_pulse,
  output reg fault_pulse,
  output reg refused_pulse
);
  reg faulted_reg;

  // Ready drops on a start to an unprotected block, returns on clean done; a fault latches busy
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      ready_reg <= 1'b1;
      faulted_reg <= 1'b0;
      array_go <= 1'b0;
      done_pulse <= 1'b0;
      fault_pulse <= 1'b0;
      refused_pulse <= 1'b0;
    end
    else
    begin
      array_go <= 1'b0;
      done_pulse <= 1'b0;
      fault_pulse <= 1'b0;
      refused_pulse <= 1'b0;
      if (reset_cmd_pulse && !faulted_reg)
        ready_reg <= 1'b1; // Clears a stuck non-fault busy state
      else if (start_pulse && ready_reg)
      begin
        if (target_protected)
          refused_pulse <= 1'b1; // Protected block left untouched
        else
        begin
          ready_reg <= 1'b0;
          array_go <= 1'b1;
        end
      end
      else if (!ready_reg && !faulted_reg && array_fault)
      begin
        faulted_reg <= 1'b1; // Only hardware reset releases this
        fault_pulse <= 1'b1;
      end
      else if (!ready_reg && !faulted_reg && array_done)
      begin
        ready_reg <= 1'b1;
        done_pulse <= 1'b1;
      end
    end
  end
endmodule // auto_op_sequencer

// ===== logic/rom_protect_gate.v
`timescale 1ns/10ps
`include "flash_status_protect_consts.vh"
// Decides whether ROM data protection is in force
module rom_protect_gate
(
  // Inputs
  input wire enable_bit,
  input wire [3:0] block_flags,
  input wire fetch_from_rom,
  // Outputs
  output wire protect_active,
  output wire access_allowed
);
  // Needs enable and every block protected
  assign protect_active = enable_bit && (block_flags == `ALL_BLOCKS);
  // Non-ROM code locked out while active
  assign access_allowed = !protect_active || fetch_from_rom;
endmodule // rom_protect_gate

// ===== logic/flash_status_protect_regs.v
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "flash_status_protect_consts.vh"
// Status and ROM protection registers on APB
module flash_status_protect_regs
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  input wire power_on_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Core side
  input wire fetch_from_rom,
  input wire mask_rom_strap,
  input wire [3:0] block_protect_in,
  input wire [1:0] target_block,
  // Flash array
  input wire array_done,
  input wire array_fault,
  output wire array_go,
  output wire rom_protect_active,
  // Interrupt
  output wire irq
);
  reg rom_prot_reg;
  reg kind_reg;
  reg [3:0] prot_reg;
  reg [`IRQ_WIDTH-1:0] irq_status_reg;
  reg [`IRQ_WIDTH-1:0] irq_mask_reg;
  reg [`IRQ_WIDTH-1:0] irq_status_next;
  reg [31:0] rdata_next;
  wire ready_flag;
  wire done_pulse;
  wire fault_pulse;
  wire refused_pulse;
  wire access_ok;
  wire wr_access;
  wire rd_access;
  wire start_pulse;
  wire reset_cmd_pulse;
  wire addr_ok;

  // Address decode used only for the error response
  function is_mapped;
    input [31:0] a;
    begin
      is_mapped = (a == `ROM_PROTECT_CONTROL_ADDR) || (a == `FLASH_CONTROL_STATUS_ADDR) ||
                  (a == `IRQ_STATUS_ADDR) || (a == `IRQ_MASK_ADDR) || (a == `FLASH_COMMAND_ADDR);
    end
  endfunction

  // Zero wait state slave
  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign addr_ok = is_mapped(paddr);
  // Blocked protect register access reports an error
  assign pslverr = psel && penable && (!addr_ok || ((paddr == `ROM_PROTECT_CONTROL_ADDR) && !access_ok));
  // Status register has no write path
  assign start_pulse = wr_access && (paddr == `FLASH_COMMAND_ADDR) && (pwdata[1:0] == `CMD_START);
  assign reset_cmd_pulse = wr_access && (paddr == `FLASH_COMMAND_ADDR) && (pwdata[1:0] == `CMD_RESET);

  auto_op_sequencer u_seq
  (
    .core_clk(core_clk),
    .rst(rst),
    .start_pulse(start_pulse),
    .reset_cmd_pulse(reset_cmd_pulse),
    .target_protected(prot_reg[target_block]),
    .array_done(array_done),
    .array_fault(array_fault),
    .array_go(array_go),
    .ready_reg(ready_flag),
    .done_pulse(done_pulse),
    .fault_pulse(fault_pulse),
    .refused_pulse(refused_pulse)
  );

  rom_protect_gate u_gate
  (
    .enable_bit(rom_prot_reg),
    .block_flags(prot_reg),
    .fetch_from_rom(fetch_from_rom),
    .protect_active(rom_protect_active),
    .access_allowed(access_ok)
  );

  // Protect enable survives ordinary resets; only power-on reset forces it to one
  always @(posedge core_clk)
  begin
    if (power_on_rst)
      rom_prot_reg <= `ROM_PROT_RESET;
    else if (wr_access && (paddr == `ROM_PROTECT_CONTROL_ADDR) && access_ok)
      rom_prot_reg <= pwdata[0];
  end

  // Type and block flags sampled from synchronous strap/array inputs
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      kind_reg <= 1'b0;
      prot_reg <= 4'h0;
    end
    else
    begin
      kind_reg <= mask_rom_strap;
      prot_reg <= block_protect_in;
    end
  end

  // Sticky events; set beats the read-clear
  always @*
  begin
    irq_status_next = irq_status_reg;
    // Clear only what setup captured, so an event landing in between survives
    if (rd_access && (paddr == `IRQ_STATUS_ADDR))
      irq_status_next = irq_status_reg & ~prdata[`IRQ_WIDTH-1:0];
    irq_status_next = irq_status_next | {refused_pulse, fault_pulse, done_pulse};
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_status_reg <= {`IRQ_WIDTH{1'b0}};
      irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      if (wr_access && (paddr == `IRQ_MASK_ADDR))
        irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read mux; reserved bits read zero
  always @*
  begin
    rdata_next = 32'h00000000;
    case (paddr)
      `FLASH_CONTROL_STATUS_ADDR:
      begin
        rdata_next[`FCS_READY_BIT] = ready_flag;
        rdata_next[`FCS_KIND_BIT] = kind_reg;
        rdata_next[`FCS_PROT_MSB:`FCS_PROT_LSB] = prot_reg;
      end
      `ROM_PROTECT_CONTROL_ADDR: rdata_next[0] = access_ok ? rom_prot_reg : 1'b0;
      `IRQ_STATUS_ADDR: rdata_next[`IRQ_WIDTH-1:0] = irq_status_reg;
      `IRQ_MASK_ADDR: rdata_next[`IRQ_WIDTH-1:0] = irq_mask_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Read data registered during setup phase, valid in access phase
  always @(posedge core_clk)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_next;
  end
endmodule // flash_status_protect_regs

// ===== verification/flash_status_protect_asserts.sv
`timescale 1ns/10ps
`include "flash_status_protect_consts.vh"
// Watches the register block from its ports only
module flash_status_protect_asserts
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  // Core and array
  input wire mask_rom_strap,
  input wire [3:0] block_protect_in,
  input wire array_fault,
  input wire array_go,
  input wire rom_protect_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Read access phases of the two registers
  wire rd_acc = psel && penable && !pwrite;
  wire fcs_rd = rd_acc && paddr == `FLASH_CONTROL_STATUS_ADDR;
  wire rp_rd = rd_acc && paddr == `ROM_PROTECT_CONTROL_ADDR;
  // A fault must be followed by eight cycles without a launch
  sequence go_quiet;
    !array_go [*8];
  endsequence
  go_pulse_a: assert property (array_go |=> !array_go) else $error("start pulse too long");
  fault_holds_a: assert property (array_fault |=> go_quiet) else $error("start after fault");
  // Data captured at setup from flags loaded one edge earlier
  kind_bit_a: assert property (fcs_rd |-> prdata[2] == $past(mask_rom_strap, 2))
    else $error("kind bit wrong");
  block_flags_a: assert property (fcs_rd |-> prdata[7:4] == $past(block_protect_in, 2))
    else $error("block flags wrong");
  fcs_zero_a: assert property (fcs_rd |-> prdata[31:8] == 24'h0 && !prdata[3] && !prdata[1])
    else $error("status spare bits set");
  rp_zero_a: assert property (rp_rd |-> prdata[31:1] == 31'h0) else $error("protect spare bits set");
  active_all_a: assert property (rom_protect_active |-> &$past(block_protect_in))
    else $error("protection without all blocks");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
  fcs_no_err_a: assert property (psel && penable && paddr == `FLASH_CONTROL_STATUS_ADDR |-> !pslverr)
    else $error("status access errored");
endmodule // flash_status_protect_asserts

bind flash_status_protect_regs flash_status_protect_asserts chk_i (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .mask_rom_strap, .block_protect_in, .array_fault, .array_go, .rom_protect_active);

// ===== verification/flash_status_protect_regs_test.sv
`timescale 1ns/10ps
`include "flash_status_protect_consts.vh"
module flash_status_protect_regs_test;
  localparam [31:0] RP = `ROM_PROTECT_CONTROL_ADDR;
  localparam [31:0] FCS = `FLASH_CONTROL_STATUS_ADDR;
  localparam [31:0] IS = `IRQ_STATUS_ADDR;
  localparam [31:0] IM = `IRQ_MASK_ADDR;
  localparam [31:0] CMD = `FLASH_COMMAND_ADDR;
  typedef struct packed {logic [31:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  // Inputs, all valued at time zero
  reg core_clk = 0, rst = 1, power_on_rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  reg fetch_from_rom = 0, mask_rom_strap = 0, array_done = 0, array_fault = 0;
  reg [31:0] paddr = 0, pwdata = 0, r;
  reg [3:0] block_protect_in = 0;
  reg [1:0] target_block = 0;
  wire pready, pslverr, array_go, rom_protect_active, irq;
  wire [31:0] prdata;
  integer error_cnt = 0, comparisons = 0, i;
  // Writes then read-backs; last row is an unmapped address
  row_t rows [0:6] = '{'{RP, 1'b1, 32'h0, 32'h0, 1'b0}, '{RP, 1'b0, 32'h0, 32'h0, 1'b0},
    '{RP, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0}, '{RP, 1'b0, 32'h0, 32'h1, 1'b0},
    '{FCS, 1'b1, 32'hFFFFFFFF, 32'h0, 1'b0}, '{FCS, 1'b0, 32'h0, 32'h1, 1'b0},
    '{32'hFFFFE530, 1'b0, 32'h0, 32'h0, 1'b1}};
  flash_status_protect_regs dut (.core_clk, .rst, .power_on_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .fetch_from_rom, .mask_rom_strap, .block_protect_in, .target_block,
    .array_done, .array_fault, .array_go, .rom_protect_active, .irq);
  initial forever #2.5 core_clk = ~core_clk;
  task end_of_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready seen high
  task bus(input [31:0] a, input w, input [31:0] d, output [31:0] rd_v, output er);
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [31:0] a, d);
    bus(a, 1'b1, d, r, e);
  endtask
  task rd(input [31:0] a, x, input ee);
    bus(a, 1'b0, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  // Let pending register updates land before looking; 0 irq, 1 protection, 2 start pulse
  task lvl(input [1:0] s, input ee);
    repeat ((s == 2'd2) ? 1 : 2) @(negedge core_clk);
    chk({31'h0, ((s == 2'd0) ? irq : ((s == 2'd1) ? rom_protect_active : array_go))}, {31'h0, ee});
  endtask
  task pulse(input k);
    @(posedge core_clk);
    if (k)
      array_fault <= 1'b1;
    else
      array_done <= 1'b1;
    @(posedge core_clk);
    array_fault <= 1'b0;
    array_done <= 1'b0;
  endtask
  // Watchdog at 1000 cycles, far beyond the roughly 120 needed
  initial
  begin
    #5000;
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0; power_on_rst <= 1'b0;
    rd(FCS, 32'h1, 1'b0);
    rd(RP, 32'h1, 1'b0);
    for (i = 0; i < 7; i++)
    begin
      bus(rows[i].a, rows[i].w, rows[i].d, r, e);
      if (!rows[i].w && !rows[i].e) chk(r, rows[i].x);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    mask_rom_strap <= 1'b1;
    block_protect_in <= 4'hA;
    target_block <= 2'h1;
    rd(FCS, 32'hA5, 1'b0);
    // Start aimed at a protected block is refused
    wr(IM, 32'h7);
    wr(CMD, 32'h1);
    lvl(2'd2, 1'b0);
    rd(FCS, 32'hA5, 1'b0);
    lvl(2'd0, 1'b1);
    rd(IS, 32'h4, 1'b0);
    lvl(2'd0, 1'b0);
    target_block <= 2'h0;
    wr(CMD, 32'h1);
    lvl(2'd2, 1'b1);
    rd(FCS, 32'hA4, 1'b0);
    pulse(1'b0);
    rd(FCS, 32'hA5, 1'b0);
    rd(IS, 32'h1, 1'b0);
    // Reset command ends a busy state that did not fault
    wr(CMD, 32'h1);
    wr(CMD, 32'h2);
    rd(FCS, 32'hA5, 1'b0);
    // Fault with its interrupt masked; reset command cannot recover
    wr(IM, 32'h0);
    wr(CMD, 32'h1);
    pulse(1'b1);
    rd(FCS, 32'hA4, 1'b0);
    lvl(2'd0, 1'b0);
    wr(CMD, 32'h2);
    rd(FCS, 32'hA4, 1'b0);
    rd(IS, 32'h2, 1'b0);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd(FCS, 32'hA5, 1'b0);
    // All blocks plus enable: non-ROM access is refused
    block_protect_in <= 4'hF;
    lvl(2'd1, 1'b1);
    rd(RP, 32'h0, 1'b1);
    wr(RP, 32'h0);
    lvl(2'd1, 1'b1);
    fetch_from_rom <= 1'b1;
    wr(RP, 32'h0);
    fetch_from_rom <= 1'b0;
    lvl(2'd1, 1'b0);
    rd(RP, 32'h0, 1'b0);
    end_of_test;
  end
endmodule // flash_status_protect_regs_test
